// ===== tb_system_watchdog_timer.sv
// Self-checking bench for the watchdog core over classic Wishbone.
// Assumes wdt_pkg, the design and wdt_props are compiled before it.
module tb_system_watchdog_timer;
    timeunit 1ns;
    timeprecision 1ns;
    import wdt_pkg::*;

    // ========================================================================
    // Signals
    localparam int TO_BASE = 4;
    logic              clk_i = 0, rst_i = 1, ce_i = 1, osc_i = 0;
    logic              wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [3:0]        wb_adr_i = 4'h0, wb_sel_i = 4'hF, osc_cnt = 4'h0;
    logic [31:0]       wb_dat_i = 32'h0, wb_dat_o, seed;
    logic              wb_ack_o, irq_o, sys_reset_o, always_on_fuse_i = 0;
    logic              kick_i = 0, irq_vector_i = 0, global_irq_en_i = 1;
    logic [7:0]        exp_q[$];
    int                error_cnt = 0, samples_checked = 0, rst_cnt = 0;
    int                n, r0;

    wdt_core #(.TIMEOUT_BASE(TO_BASE)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .osc_i(osc_i), .always_on_fuse_i(always_on_fuse_i),
        .kick_i(kick_i), .irq_vector_i(irq_vector_i),
        .global_irq_en_i(global_irq_en_i), .irq_o(irq_o),
        .sys_reset_o(sys_reset_o));

    // ========================================================================
    // Clock and slow oscillator, one tick every 16 cycles to keep runs short
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        osc_cnt <= osc_cnt + 4'h1;
        osc_i   <= osc_cnt[3];
    end

    // ========================================================================
    // Tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test;
        $display("checks=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    // One classic cycle; holds everything until ack is sampled high
    task automatic wb_cycle(input logic w, input logic [3:0] a,
                            input logic [7:0] d);
        int k;
        k = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h000000, d};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && k < 20)
        begin
            @(posedge clk_i);
            k++;
        end
        if (k == 20)
        begin
            error_cnt++;
            finish_test();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb_cycle

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        wb_cycle(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        wb_cycle(1'b0, a, 8'h00);
    endtask : rd

    // Timed unlock then protected write, back to back
    task automatic prot(input logic [7:0] d);
        wr(ADDR_CTRL, 8'h18);
        wr(ADDR_CTRL, d);
    endtask : prot

    task automatic kick;
        kick_i <= 1'b1;
        @(posedge clk_i);
        kick_i <= 1'b0;
    endtask : kick

    // Bounded wait for an interrupt or a system reset pulse
    task automatic wait_evt(input bit rst_evt, input int lim, output int k);
        k = 0;
        while ((rst_evt ? sys_reset_o : irq_o) !== 1'b1 && k < lim)
        begin
            @(posedge clk_i);
            k++;
        end
        check(8'(k < lim), 8'h01);
        if (k == lim)
            finish_test();
    endtask : wait_evt

    // ========================================================================
    // Read-data monitor, oldest expectation first
    always @(posedge clk_i)
    begin
        if (sys_reset_o === 1'b1)
            rst_cnt++;
        if (wb_ack_o === 1'b1 && !wb_we_i && exp_q.size() > 0)
            check(wb_dat_o[7:0], exp_q.pop_front());
    end

    // ========================================================================
    // Main sequence
    initial
    begin
        seed = 32'h5DEB;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(ADDR_CTRL, 8'h00);
        rd(ADDR_RSTAT, 8'h00);
        wr(4'h8, 8'($random(seed)));
        rd(4'h8, 8'h00);
        // Interrupt mode, period per prescale code 0 to 3
        for (int c = 0; c < 4; c++)
        begin
            // Protected write also clears the flag left by the last pass
            prot(8'h80 | 8'(c));
            rd(ADDR_CTRL, 8'(c));
            kick();
            wr(ADDR_CTRL, 8'hC0 | 8'(c));
            @(posedge clk_i);
            wait_evt(1'b0, 2000, n);
            check(8'((n + 5 + 32) / (16 * TO_BASE)), 8'(1 << c));
        end
        global_irq_en_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check(8'(irq_o), 8'h00);
        global_irq_en_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        check(8'(irq_o), 8'h01);
        wr(ADDR_CTRL, 8'h43);
        rd(ADDR_CTRL, 8'hC3);
        wr(ADDR_CTRL, 8'hC3);
        rd(ADDR_CTRL, 8'h43);
        // Stopped mode does nothing
        wr(ADDR_CTRL, 8'h03);
        r0 = rst_cnt;
        repeat (600) @(posedge clk_i);
        check(8'(irq_o), 8'h00);
        check(8'(rst_cnt - r0), 8'h00);
        // Reset mode; kick first so a shorter period cannot fire at once
        kick();
        prot(8'h08);
        r0 = rst_cnt;
        repeat (8)
        begin
            kick();
            repeat (4 + ($random(seed) & 15)) @(posedge clk_i);
        end
        check(8'(rst_cnt - r0), 8'h00);
        wait_evt(1'b1, 200, n);
        rd(ADDR_RSTAT, 8'h08);
        rd(ADDR_CTRL, 8'h08);
        prot(8'h00);
        rd(ADDR_CTRL, 8'h08);
        kick();
        wr(ADDR_RSTAT, 8'h08);
        rd(ADDR_RSTAT, 8'h08);
        wr(ADDR_RSTAT, 8'h00);
        rd(ADDR_RSTAT, 8'h00);
        kick();
        wr(ADDR_CTRL, 8'h08);
        wr(ADDR_CTRL, 8'h01);
        rd(ADDR_CTRL, 8'h08);
        kick();
        wr(ADDR_CTRL, 8'h18);
        rd(ADDR_CTRL, 8'h18);
        repeat (2) @(posedge clk_i);
        wr(ADDR_CTRL, 8'h00);
        rd(ADDR_CTRL, 8'h08);
        // Combined mode: flag first, vector, then reset
        kick();
        wr(ADDR_CTRL, 8'h48);
        r0 = rst_cnt;
        wait_evt(1'b0, 200, n);
        check(8'(rst_cnt - r0), 8'h00);
        repeat (4) @(posedge clk_i);
        irq_vector_i <= 1'b1;
        @(posedge clk_i);
        irq_vector_i <= 1'b0;
        rd(ADDR_CTRL, 8'h08);
        wait_evt(1'b1, 200, n);
        kick();
        wr(ADDR_CTRL, 8'h48);
        wait_evt(1'b0, 200, n);
        wait_evt(1'b1, 100, n);
        // Fuse forces reset mode
        kick();
        wr(ADDR_RSTAT, 8'h00);
        prot(8'h80);
        rd(ADDR_CTRL, 8'h00);
        always_on_fuse_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rd(ADDR_CTRL, 8'h08);
        wr(ADDR_CTRL, 8'h40);
        rd(ADDR_CTRL, 8'h08);
        wait_evt(1'b1, 200, n);
        finish_test();
    end
endmodule : tb_system_watchdog_timer

bind wdt_core wdt_props #(.TIMEOUT_BASE(TIMEOUT_BASE)) u_props (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .osc_i(osc_i), .always_on_fuse_i(always_on_fuse_i), .kick_i(kick_i),
    .irq_vector_i(irq_vector_i), .global_irq_en_i(global_irq_en_i),
    .irq_o(irq_o), .sys_reset_o(sys_reset_o));

// ===== wdt_core.sv
// Watchdog top: Wishbone register slave, unlock sequence, mode logic.
// Assumes osc_i is the free-running slow oscillator as a plain level, and
// that kick, vector and global enable come from core logic on clk_i.
//
// The Wishbone interface to the registers and the address map were chosen for this implementation.
module wdt_core #(
    parameter int TIMEOUT_BASE = wdt_pkg::BASE_TIMEOUT,
    parameter int CNT_W        = wdt_pkg::CNT_WIDTH
) (
    // Clock, reset, enable
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     ce_i,
    // Wishbone slave
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [wdt_pkg::WB_AW-1:0] wb_adr_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic [wdt_pkg::WB_DW-1:0] wb_dat_i,
    output logic      [wdt_pkg::WB_DW-1:0] wb_dat_o,
    output logic                          wb_ack_o,
    // Oscillator and fuse pins
    input  wire logic                     osc_i,
    input  wire logic                     always_on_fuse_i,
    // Core side
    input  wire logic                     kick_i,
    input  wire logic                     irq_vector_i,
    input  wire logic                     global_irq_en_i,
    // Results
    output logic                          irq_o,
    output logic                          sys_reset_o
);
    import wdt_pkg::*;

    // ========================================================================
    // Elaboration checks
    if (TIMEOUT_BASE < 1)
    begin : g_chk_base
        $error("TIMEOUT_BASE must be at least one");
    end
    if (CNT_W < 2 || CNT_W > 31 ||
        (longint'(TIMEOUT_BASE) << 9) > (longint'(1) << CNT_W))
    begin : g_chk_width
        $error("CNT_W cannot hold the longest time-out");
    end

    // ========================================================================
    // Declarations
    logic [2:0]       osc_sync;
    logic [1:0]       fuse_sync;
    logic             osc_tick;
    logic             fuse;
    logic             expire;
    logic             timeout_flag;
    logic             timeout_irq_enable;
    logic             system_reset_enable;
    logic [3:0]       prescale_select;
    logic [2:0]       unlock_cnt;
    logic             change_unlock_bit;
    logic             watchdog_reset_cause_flag;
    logic             re_eff;
    logic             ie_eff;
    logic             req;
    logic             wr_ctrl;
    logic             wr_rstat;
    logic [7:0]       wd;
    logic             unlock_req;
    logic             prot_wr;
    logic             set_flag;
    logic             do_reset;
    logic [CNT_W-1:0] limit;

    // ========================================================================
    // Helpers
    // Reserved prescale codes fall back to the longest period
    function automatic logic [CNT_W-1:0] timeout_limit(
        input logic [3:0] code
    );
        logic [3:0] c;
        c = (code > PS_MAX_CODE) ? PS_MAX_CODE : code;
        return CNT_W'(TIMEOUT_BASE) << c;
    endfunction : timeout_limit

    // Register image of the control/status byte
    function automatic logic [7:0] ctrl_image(
        input logic       flag,
        input logic       ie,
        input logic [3:0] ps,
        input logic       unl,
        input logic       re
    );
        logic [7:0] v;
        v               = 8'h00;
        v[BIT_FLAG]     = flag;
        v[BIT_IE]       = ie;
        v[BIT_PS3]      = ps[3];
        v[BIT_UNLOCK]   = unl;
        v[BIT_RE]       = re;
        v[BIT_PS_HI:BIT_PS_LO] = ps[2:0];
        return v;
    endfunction : ctrl_image

    // ========================================================================
    // Pin synchronisers
    // Stage 0 feeds stage 1 only; stages 1 and 2 form the edge detector
    // All ones after reset: no false rising edge whatever the pin level
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            osc_sync  <= 3'h7;
            fuse_sync <= 2'h0;
        end
        else if (ce_i)
        begin
            osc_sync  <= {osc_sync[1:0], osc_i};
            fuse_sync <= {fuse_sync[0], always_on_fuse_i};
        end
    end

    // Rising oscillator edge; the counter never sees the raw pin
    assign osc_tick = osc_sync[1] & ~osc_sync[2];
    assign fuse     = fuse_sync[1];

    // ========================================================================
    // Effective mode bits
    assign re_eff = system_reset_enable | fuse
                  | watchdog_reset_cause_flag;
    assign ie_eff = timeout_irq_enable & ~fuse;

    // ========================================================================
    // Bus decode
    // Writes land on the edge where the master sees ack high
    assign req      = wb_cyc_i & wb_stb_i;
    assign wd       = wb_dat_i[7:0];
    assign wr_ctrl  = req & wb_ack_o & wb_we_i & wb_sel_i[0]
                    & (wb_adr_i == ADDR_CTRL);
    assign wr_rstat = req & wb_ack_o & wb_we_i & wb_sel_i[0]
                    & (wb_adr_i == ADDR_RSTAT);

    // Unlock needs both bits in one write, whatever reset enable was
    assign change_unlock_bit = (unlock_cnt != 3'h0);
    assign unlock_req = wr_ctrl & wd[BIT_UNLOCK] & wd[BIT_RE];
    assign prot_wr    = wr_ctrl & change_unlock_bit
                      & ~wd[BIT_UNLOCK];

    // ========================================================================
    // Time-out actions
    // A flag still pending at a second combined-mode time-out means reset
    assign set_flag = expire & ie_eff
                    & ~(re_eff & timeout_flag);
    assign do_reset = expire & re_eff
                    & (~ie_eff | timeout_flag);

    // ========================================================================
    // Wishbone acknowledge and read data
    // Registered ack: one wait state, ack drops after one cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else if (ce_i)
        begin
            wb_ack_o <= req & ~wb_ack_o;
            if (req & ~wb_ack_o)
            begin
                if (wb_adr_i == ADDR_CTRL)
                begin
                    wb_dat_o <= WB_DW'(ctrl_image(timeout_flag, ie_eff,
                        prescale_select, change_unlock_bit, re_eff));
                end
                else if (wb_adr_i == ADDR_RSTAT)
                begin
                    wb_dat_o <= WB_DW'({watchdog_reset_cause_flag,
                                        3'h0});
                end
                else
                begin
                    wb_dat_o <= '0;
                end
            end
        end
    end

    // ========================================================================
    // Unlock window counter
    // The protected write itself closes the window at once
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            unlock_cnt <= 3'h0;
        end
        else if (ce_i)
        begin
            if (prot_wr)
            begin
                unlock_cnt <= 3'h0;
            end
            else if (unlock_req)
            begin
                unlock_cnt <= UNLOCK_CYCLES;
            end
            else if (change_unlock_bit)
            begin
                unlock_cnt <= unlock_cnt - 3'h1;
            end
        end
    end

    // ========================================================================
    // Reset enable and prescale
    // Setting reset enable is always allowed; clearing is guarded
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            system_reset_enable <= RST_RE;
            prescale_select     <= RST_PS;
        end
        else if (ce_i)
        begin
            if (prot_wr)
            begin
                system_reset_enable <= wd[BIT_RE];
                prescale_select     <= {wd[BIT_PS3],
                                        wd[BIT_PS_HI:BIT_PS_LO]};
            end
            else if (wr_ctrl & wd[BIT_RE])
            begin
                system_reset_enable <= 1'b1;
            end
        end
    end

    // ========================================================================
    // Interrupt enable
    // Software set beats the vector clear in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            timeout_irq_enable <= RST_IE;
        end
        else if (ce_i)
        begin
            if (fuse)
            begin
                timeout_irq_enable <= 1'b0;
            end
            else if (wr_ctrl)
            begin
                timeout_irq_enable <= wd[BIT_IE];
            end
            else if (irq_vector_i & re_eff)
            begin
                timeout_irq_enable <= 1'b0;
            end
        end
    end

    // ========================================================================
    // Time-out flag
    // A new time-out beats any clear arriving in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            timeout_flag <= RST_FLAG;
        end
        else if (ce_i)
        begin
            if (set_flag)
            begin
                timeout_flag <= 1'b1;
            end
            else if (irq_vector_i | (wr_ctrl & wd[BIT_FLAG]))
            begin
                timeout_flag <= 1'b0;
            end
        end
    end

    // ========================================================================
    // Reset-cause flag
    // Only the power-on reset input or a written zero clears it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            watchdog_reset_cause_flag <= RST_CAUSE;
        end
        else if (ce_i)
        begin
            if (do_reset)
            begin
                watchdog_reset_cause_flag <= 1'b1;
            end
            else if (wr_rstat & ~wd[BIT_CAUSE])
            begin
                watchdog_reset_cause_flag <= 1'b0;
            end
        end
    end

    // ========================================================================
    // Outputs
    // Interrupt level also serves as the wake-up request in sleep
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_o       <= 1'b0;
            sys_reset_o <= 1'b0;
        end
        else if (ce_i)
        begin
            irq_o       <= timeout_flag & ie_eff
                         & global_irq_en_i;
            sys_reset_o <= do_reset;
        end
    end

    // ========================================================================
    // Time-out counter
    // Limit follows the stored select only, so partial writes never reach it
    assign limit = timeout_limit(prescale_select);

    wdt_tick_counter #(
        .CNT_W     (CNT_W)
    ) u_counter (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .tick_i    (osc_tick),
        .restart_i (kick_i),
        .limit_i   (limit),
        .expire_o  (expire)
    );

endmodule : wdt_core

// ===== wdt_core_props.sv
// Checker for the watchdog core, watching only the top-level ports.
// Assumes one clock domain, synchronous high reset, ce_i held high.
module wdt_props #(
    parameter int TIMEOUT_BASE = 4
) (
    // Clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    // Bus
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_ack_o,
    input  wire logic [wdt_pkg::WB_DW-1:0] wb_dat_o,
    // Pins and core side
    input  wire logic                      osc_i,
    input  wire logic                      always_on_fuse_i,
    input  wire logic                      kick_i,
    input  wire logic                      irq_vector_i,
    input  wire logic                      global_irq_en_i,
    // Results
    input  wire logic                      irq_o,
    input  wire logic                      sys_reset_o
);
    import wdt_pkg::*;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ========================================================================
    // Helper counters
    logic        osc_q;
    logic [7:0]  since_rise;
    logic [15:0] rises;
    wire         osc_rise = osc_i && !osc_q;

    // Last oscillator level, for edge detection
    always_ff @(posedge clk_i)
        osc_q <= osc_i;

    // Cycles since the last oscillator rise, saturating
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            since_rise <= 8'hFF;
        else if (osc_rise)
            since_rise <= 8'h00;
        else if (since_rise != 8'hFF)
            since_rise <= since_rise + 8'h01;
    end

    // Rises since last restart; may miss one near a kick, hence slack
    always_ff @(posedge clk_i)
    begin
        if (rst_i || kick_i || sys_reset_o)
            rises <= 16'h0000;
        else if (osc_rise && rises != 16'hFFFF)
            rises <= rises + 16'h0001;
    end

    // ========================================================================
    // Properties
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_fuse_held;
        always_on_fuse_i [*6];
    endsequence

    property p_ack_wait;
        s_req |=> wb_ack_o;
    endproperty
    property p_ack_cause;
        wb_ack_o |-> $past(wb_stb_i) && wb_cyc_i;
    endproperty
    property p_dat_high;
        wb_ack_o |-> wb_dat_o[31:8] == 24'h000000;
    endproperty
    property p_reset_pulse;
        sys_reset_o |=> !sys_reset_o;
    endproperty
    property p_reset_tick;
        sys_reset_o |-> since_rise <= 8'h08;
    endproperty
    property p_kick_restart;
        sys_reset_o |-> rises >= 16'(TIMEOUT_BASE - 1);
    endproperty
    property p_irq_global;
        irq_o |-> $past(global_irq_en_i);
    endproperty
    property p_fuse_no_irq;
        s_fuse_held |-> !irq_o;
    endproperty
    property p_vector_clear;
        irq_vector_i && since_rise > 8'h08 |-> ##2 !irq_o;
    endproperty

    a_ack_wait: assert property (p_ack_wait)
        else $error("ack missing one cycle after request");
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without a request");
    a_dat_high: assert property (p_dat_high)
        else $error("read data upper bits not zero");
    a_reset_pulse: assert property (p_reset_pulse)
        else $error("system reset longer than one cycle");
    a_reset_tick: assert property (p_reset_tick)
        else $error("system reset not caused by an oscillator tick");
    a_kick_restart: assert property (p_kick_restart)
        else $error("system reset too soon after restart");
    a_irq_global: assert property (p_irq_global)
        else $error("interrupt without global enable");
    a_fuse_no_irq: assert property (p_fuse_no_irq)
        else $error("interrupt while fuse programmed");
    a_vector_clear: assert property (p_vector_clear)
        else $error("interrupt not cleared by vector");
endmodule : wdt_props

// ===== wdt_pkg.sv
// Shared constants for the system watchdog: register map, field positions,
// reset values and timing counts.
// Assumes a 32-bit classic Wishbone master and a 100 MHz system clock.
//
// Behaviour
// - Counter advances on slow oscillator ticks only
// - Kick restarts counter, else time-out acts
// - Interrupt-only mode flags; stopped mode does nothing
// - Reset-only mode pulses system reset on time-out
// - Combined mode: flag first, vector clears enable
// - Combined mode, unserviced flag: next time-out resets
// - Fuse forces reset enable one, irq enable zero
// - Unlock bit self-clears after four clock cycles
// - Clear reset enable, change prescale only unlocked
// - Flag bit 7 set on time-out in irq mode
// - Flag cleared by vector or writing one
// - Interrupt needs flag, enable and global enable
// - Reset-cause flag forces reset enable set
// - Four prescale bits pick the time-out count
// - Interrupt serves as wake-up during sleep
// - Codes 0..9 double 2048 to 1048576 ticks
// - Watchdog reset is a one-cycle pulse
// - Cause flag set on reset, cleared writing zero
package wdt_pkg;

    // ========================================================================
    // Bus geometry
    localparam int WB_AW = 4;
    localparam int WB_DW = 32;

    // ========================================================================
    // Register byte offsets
    localparam logic [WB_AW-1:0] ADDR_CTRL  = 4'h0;
    localparam logic [WB_AW-1:0] ADDR_RSTAT = 4'h4;

    // ========================================================================
    // Control/status field positions
    localparam int BIT_FLAG   = 7;
    localparam int BIT_IE     = 6;
    localparam int BIT_PS3    = 5;
    localparam int BIT_UNLOCK = 4;
    localparam int BIT_RE     = 3;
    localparam int BIT_PS_HI  = 2;
    localparam int BIT_PS_LO  = 0;

    // Reset status field position
    localparam int BIT_CAUSE  = 3;

    // ========================================================================
    // Reset values
    localparam logic       RST_FLAG  = 1'b0;
    localparam logic       RST_IE    = 1'b0;
    localparam logic       RST_RE    = 1'b0;
    localparam logic       RST_CAUSE = 1'b0;
    localparam logic [3:0] RST_PS    = 4'h0;

    // ========================================================================
    // Timing
    localparam int         OSC_FREQ_KHZ  = 128;
    localparam int         BASE_TIMEOUT  = 2048;
    localparam logic [3:0] PS_MAX_CODE   = 4'h9;
    localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
    localparam int         CNT_WIDTH     = 20;

endpackage : wdt_pkg

// ===== wdt_tick_counter.sv
// Time-out counter of the watchdog, stepped by oscillator ticks.
// Assumes tick_i is a one-cycle pulse already brought into clk_i's domain.
module wdt_tick_counter #(
    parameter int CNT_W = wdt_pkg::CNT_WIDTH
) (
    // Clock, reset, enable
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    // Control
    input  wire logic             tick_i,
    input  wire logic             restart_i,
    input  wire logic [CNT_W-1:0] limit_i,
    // Event
    output logic                  expire_o
);
    import wdt_pkg::*;

    logic [CNT_W-1:0] count;
    logic             at_end;

    // ========================================================================
    // Count compare
    // Greater-or-equal so a shortened period fires at once, not after wrap
    assign at_end = (count >= limit_i - CNT_W'(1));

    // Tick counter; a kick beats a coinciding time-out
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            count    <= '0;
            expire_o <= 1'b0;
        end
        else if (ce_i)
        begin
            expire_o <= 1'b0;
            if (restart_i)
            begin
                count <= '0;
            end
            else if (tick_i)
            begin
                if (at_end)
                begin
                    count    <= '0;
                    expire_o <= 1'b1;
                end
                else
                begin
                    count <= CNT_W'(count + CNT_W'(1));
                end
            end
        end
    end

endmodule : wdt_tick_counter
